// [common/itt_pkg.sv]
// constants shared by the interval and time-base timer
package itt_pkg;

  // ************************************************************
  // register indices and byte addresses
  // ************************************************************
  localparam int unsigned ITT_ADDR_W = 20;
  localparam logic [15:0] IDX_OUT_SEL = 16'hFF92;
  localparam logic [15:0] IDX_MODE    = 16'hFFB0;
  localparam logic [15:0] IDX_COUNT   = 16'hFFB1;
  localparam logic [15:0] IDX_CKSTOP  = 16'hFFFA;
  localparam logic [ITT_ADDR_W-1:0] ADDR_OUT_SEL = {2'h0, IDX_OUT_SEL, 2'h0};
  localparam logic [ITT_ADDR_W-1:0] ADDR_MODE    = {2'h0, IDX_MODE, 2'h0};
  localparam logic [ITT_ADDR_W-1:0] ADDR_COUNT   = {2'h0, IDX_COUNT, 2'h0};
  localparam logic [ITT_ADDR_W-1:0] ADDR_CKSTOP  = {2'h0, IDX_CKSTOP, 2'h0};

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_MODE    = 8'h10;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_OUT_SEL = 8'hFE;
  localparam logic [7:0] RST_CKSTOP  = 8'hFF;
  localparam logic [6:0] RST_SUB_PS  = 7'h00;
  localparam logic [12:0] RST_SYS_PS = 13'h0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned MODE_OUT_SEL_LSB = 5;
  localparam int unsigned MODE_FIXED_BIT   = 4;
  localparam int unsigned MODE_IN_SEL3     = 3;
  localparam int unsigned MODE_IN_SEL2     = 2;
  localparam int unsigned OUT_SEL_PASS_BIT = 0;
  localparam int unsigned CKSTOP_TMR_BIT   = 0;

  // ************************************************************
  // power mode codes
  // ************************************************************
  localparam logic [2:0] PWR_ACTIVE    = 3'h0;
  localparam logic [2:0] PWR_SLEEP     = 3'h1;
  localparam logic [2:0] PWR_WATCH     = 3'h2;
  localparam logic [2:0] PWR_SUBACTIVE = 3'h3;
  localparam logic [2:0] PWR_SUBSLEEP  = 3'h4;
  localparam logic [2:0] PWR_STANDBY   = 3'h5;

  // ************************************************************
  // counter geometry
  // ************************************************************
  localparam logic [7:0] COUNT_MAX = 8'hFF;

endpackage

// [hw/itt_sub_sync.sv]
// two-stage synchroniser and rising-edge detector for the subclock pin
`timescale 1ns/1ps
`default_nettype none

module itt_sub_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sub_clk_in,
  output logic      sub_level,
  output logic      sub_rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ************************************************************
  // synchroniser
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= sub_clk_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign sub_level = sync_r;
  assign sub_rise  = sync_r & ~prev_r;

endmodule

`default_nettype wire

// [hw/itt_timer.sv]
// interval and time-base timer with waveform output and apb registers
// Notes on behaviour
// - mode register resets to 0x10
// - codes 000-011 output system clock /32../4
// - codes 100-111 output subclock /32../4
// - system clock outputs only active, sleep
// - subclock outputs in active, sleep, subactive
// - raw subclock output in all modes
// - mode bit 4 reads one, unwritable
// - input codes 0xxx pick system prescaler tap
// - input codes 10xx pick time-base period
// - codes 11xx hold subclock prescaler and counter cleared
// - eight-bit read-only up-counter on selected clock
// - counter readable in active, not subactive
// - each overflow sets request flag
// - counter resets to 0x00
// - time base assumes 32.768 kHz subclock
// - interval counter wraps every 256 inputs
// - standby halts timer, blocks input bit 3
// - pin driven only when port enable set
// - standby bit resets to one
`timescale 1ns/1ps
`default_nettype none

module itt_timer (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [itt_pkg::ITT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           sub_clk_in,
  input  wire logic [2:0]                     pwr_mode,
  input  wire logic                           wave_out_en,
  input  wire logic                           flag_clear,
  output logic                                wave_out_pin,
  output logic                                wave_out_oe,
  output logic                                overflow_request_flag
);
  import itt_pkg::*;

  logic [7:0]  timer_mode_select_r;
  logic [7:0]  timer_count_value_r;
  logic        out_pass_r;
  logic [7:0]  module_clock_stop_r;
  logic [12:0] sys_ps_r;
  logic [6:0]  sub_ps_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        wave_r;
  logic        oe_r;
  logic        flag_r;
  logic        sub_level;
  logic        sub_rise;
  logic        setup_ph;
  logic        wr_take;
  logic        hit;
  logic [7:0]  rd_nxt;
  logic        standby_release_bit;
  logic        clear_code;
  logic        time_base;
  logic        run_ok;
  logic        tick;
  logic        wave_nxt;

  // ************************************************************
  // tap decoders
  // ************************************************************
  // system prescaler tap for divide-by 8192..8
  function automatic logic sys_tap(input logic [12:0] cnt, input logic [2:0] sel);
    logic [12:0] mask;
    mask = 13'h0000;
    unique case (sel)
      3'h0: mask = 13'h1FFF;
      3'h1: mask = 13'h0FFF;
      3'h2: mask = 13'h07FF;
      3'h3: mask = 13'h01FF;
      3'h4: mask = 13'h00FF;
      3'h5: mask = 13'h007F;
      3'h6: mask = 13'h001F;
      3'h7: mask = 13'h0007;
    endcase
    return (cnt & mask) == mask;
  endfunction

  // subclock prescaler tap: 128, 64, 32, 4 subclocks per count
  function automatic logic sub_tap(input logic [6:0] cnt, input logic [1:0] sel);
    logic [6:0] mask;
    mask = 7'h00;
    unique case (sel)
      2'h0: mask = 7'h7F;
      2'h1: mask = 7'h3F;
      2'h2: mask = 7'h1F;
      2'h3: mask = 7'h03;
    endcase
    return (cnt & mask) == mask;
  endfunction

  // ************************************************************
  // subclock input
  // ************************************************************
  itt_sub_sync u_sub_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .sub_clk_in (sub_clk_in),
    .sub_level  (sub_level),
    .sub_rise   (sub_rise)
  );

  // ************************************************************
  // control decode
  // ************************************************************
  assign standby_release_bit = module_clock_stop_r[CKSTOP_TMR_BIT];
  assign time_base  = timer_mode_select_r[MODE_IN_SEL3];
  assign clear_code = time_base & timer_mode_select_r[MODE_IN_SEL2];
  // interval counting needs the system clock; time base also runs in watch and sub modes
  assign run_ok = standby_release_bit && (pwr_mode != PWR_STANDBY) &&
                  (time_base || pwr_mode == PWR_ACTIVE || pwr_mode == PWR_SLEEP);
  assign tick = run_ok && !clear_code &&
                (time_base ? (sub_rise && sub_tap(sub_ps_r, timer_mode_select_r[1:0]))
                           : sys_tap(sys_ps_r, timer_mode_select_r[2:0]));

  // ************************************************************
  // apb decode
  // ************************************************************
  assign setup_ph = psel && !penable;
  assign wr_take  = psel && penable && pready_r && pwrite && !pslverr_r;
  assign hit = (paddr == ADDR_MODE) || (paddr == ADDR_COUNT) ||
               (paddr == ADDR_OUT_SEL) || (paddr == ADDR_CKSTOP);

  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (paddr)
      ADDR_MODE:    rd_nxt = timer_mode_select_r;
      // count is not readable from subactive mode
      ADDR_COUNT:   rd_nxt = (pwr_mode == PWR_SUBACTIVE) ? 8'h00 : timer_count_value_r;
      ADDR_OUT_SEL: rd_nxt = {RST_OUT_SEL[7:1], out_pass_r};
      ADDR_CKSTOP:  rd_nxt = module_clock_stop_r;
      default:      rd_nxt = 8'h00;
    endcase
  end

  // ************************************************************
  // apb answer, one cycle after setup
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !hit;
      if (setup_ph)
      begin
        prdata_r <= {24'h00_0000, rd_nxt};
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_mode_select_r <= RST_MODE;
    end
    else if (wr_take && paddr == ADDR_MODE)
    begin
      timer_mode_select_r[7:MODE_OUT_SEL_LSB] <= pwdata[7:MODE_OUT_SEL_LSB];
      timer_mode_select_r[MODE_FIXED_BIT] <= 1'b1;
      if (standby_release_bit)
      begin
        timer_mode_select_r[MODE_IN_SEL3] <= pwdata[MODE_IN_SEL3];
      end
      timer_mode_select_r[2:0] <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_pass_r <= RST_OUT_SEL[OUT_SEL_PASS_BIT];
    end
    else if (wr_take && paddr == ADDR_OUT_SEL)
    begin
      out_pass_r <= pwdata[OUT_SEL_PASS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      module_clock_stop_r <= RST_CKSTOP;
    end
    else if (wr_take && paddr == ADDR_CKSTOP)
    begin
      module_clock_stop_r <= pwdata[7:0];
    end
  end

  // ************************************************************
  // prescalers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_ps_r <= RST_SYS_PS;
    end
    else
    begin
      sys_ps_r <= sys_ps_r + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sub_ps_r <= RST_SUB_PS;
    end
    else if (clear_code)
    begin
      sub_ps_r <= RST_SUB_PS;
    end
    else if (sub_rise)
    begin
      sub_ps_r <= sub_ps_r + 7'h01;
    end
  end

  // ************************************************************
  // counter and overflow flag
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_count_value_r <= RST_COUNT;
    end
    else if (clear_code)
    begin
      timer_count_value_r <= RST_COUNT;
    end
    else if (tick)
    begin
      timer_count_value_r <= timer_count_value_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r <= 1'b0;
    end
    else if (tick && timer_count_value_r == COUNT_MAX)
    begin
      flag_r <= 1'b1;
    end
    else if (flag_clear)
    begin
      flag_r <= 1'b0;
    end
  end

  // ************************************************************
  // waveform output
  // ************************************************************
  always_comb
  begin
    wave_nxt = 1'b0;
    if (out_pass_r)
    begin
      wave_nxt = sub_level;
    end
    else if (timer_mode_select_r[7])
    begin
      if (pwr_mode == PWR_ACTIVE || pwr_mode == PWR_SLEEP || pwr_mode == PWR_SUBACTIVE)
      begin
        wave_nxt = sub_ps_r[3'h4 - {1'b0, timer_mode_select_r[6:5]}];
      end
    end
    else if (pwr_mode == PWR_ACTIVE || pwr_mode == PWR_SLEEP)
    begin
      wave_nxt = sys_ps_r[4'h4 - {2'h0, timer_mode_select_r[6:5]}];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_r <= 1'b0;
      oe_r   <= 1'b0;
    end
    else
    begin
      wave_r <= wave_nxt && wave_out_en;
      oe_r   <= wave_out_en;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign wave_out_pin = wave_r;
  assign wave_out_oe  = oe_r;
  assign overflow_request_flag = flag_r;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_wrap_tick;
    tick && timer_count_value_r == COUNT_MAX;
  endsequence

  sequence s_count_read;
    psel && !penable && !pwrite && paddr == ADDR_COUNT && pwr_mode == PWR_ACTIVE;
  endsequence

  a_fixed_bit_one: assert property (@(posedge pclk) disable iff (!presetn)
    timer_mode_select_r[MODE_FIXED_BIT])
    else $error("mode bit 4 not one");

  a_count_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap_tick |=> timer_count_value_r == 8'h00)
    else $error("counter did not wrap");

  a_overflow_sets: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap_tick |=> overflow_request_flag)
    else $error("overflow flag not set");

  a_count_steps: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> timer_count_value_r == $past(timer_count_value_r) + 8'h01)
    else $error("counter did not advance");

  a_clear_holds: assert property (@(posedge pclk) disable iff (!presetn)
    clear_code |=> timer_count_value_r == 8'h00 && sub_ps_r == 7'h00)
    else $error("clear code did not hold counters");

  a_standby_halt: assert property (@(posedge pclk) disable iff (!presetn)
    !standby_release_bit && !clear_code |=> $stable(timer_count_value_r))
    else $error("counter moved in module standby");

  a_pin_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !wave_out_en |=> !wave_out_pin && !wave_out_oe)
    else $error("pin driven while disabled");

  a_sys_out_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !out_pass_r && !timer_mode_select_r[7] &&
    pwr_mode != PWR_ACTIVE && pwr_mode != PWR_SLEEP |=> !wave_out_pin)
    else $error("system clock output outside active or sleep");

  a_raw_follow: assert property (@(posedge pclk) disable iff (!presetn)
    out_pass_r && wave_out_en |=> wave_out_pin == $past(sub_level))
    else $error("raw subclock not on pin");

  a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
    s_count_read |=> pready && prdata[7:0] == $past(timer_count_value_r) ##1 !pready)
    else $error("count read answer wrong");

endmodule

`default_nettype wire

// [verif/itt_tb.sv]
// self-checking testbench for the interval and time-base timer
`timescale 1ns/1ps
`default_nettype none

module tb;
  import itt_pkg::*;

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [ITT_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  sub_clk_in;
  logic [2:0]            pwr_mode;
  logic                  wave_out_en;
  logic                  flag_clear;
  logic                  wave_out_pin;
  logic                  wave_out_oe;
  logic                  overflow_request_flag;
  logic [32:0]           exp_q[$];
  logic [32:0]           e;
  int                    miscompares;
  int                    total_checks;
  int                    cyc;
  int                    c;

  itt_timer i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk_in(sub_clk_in), .pwr_mode(pwr_mode), .wave_out_en(wave_out_en),
    .flag_clear(flag_clear), .wave_out_pin(wave_out_pin), .wave_out_oe(wave_out_oe),
    .overflow_request_flag(overflow_request_flag)
  );

  // ************************************************************
  // clocks and checking helpers
  // ************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // subclock with a phase unrelated to pclk, about 30.46 pclk periods
  initial
  begin
    sub_clk_in = 1'b0;
    forever #1523 sub_clk_in = ~sub_clk_in;
  end

  task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] se);
    total_checks++;
    if (se !== ex)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, ex, se);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // read monitor: oldest note against {pslverr, prdata}
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      e = exp_q.pop_front();
      chk("prdata", e, {pslverr, prdata});
    end
  end

  // ************************************************************
  // bus and pin tasks
  // ************************************************************
  task automatic apb(input logic [ITT_ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($urandom()), d};
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50)
      chk("pready", 33'h1, 33'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [ITT_ADDR_W-1:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    apb(a, 1'b0, 8'h00);
  endtask

  task automatic wr(input logic [ITT_ADDR_W-1:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  // period between two rising edges of the pin, 0 if fewer than two
  task automatic wave(input int ex, input int tol);
    int n;
    int t;
    int r;
    int lim;
    logic p;
    n = 0;
    t = 0;
    r = 0;
    lim = (ex > 0) ? 3 * ex + 100 : 600;
    // start high: a stale level from the old setting is no edge
    p = 1'b1;
    while (r < 2 && n < lim)
    begin
      @(posedge pclk);
      n++;
      if (wave_out_pin === 1'b1 && p !== 1'b1)
      begin
        r++;
        if (r == 1)
          t = n;
      end
      p = wave_out_pin;
    end
    n = (r < 2) ? 0 : n - t;
    if (n >= ex - tol && n <= ex + tol)
      n = ex;
    chk("wave period", 33'(ex), 33'(n));
  endtask

  task automatic wait_flag(output int n);
    n = 1;
    @(posedge pclk);
    while (overflow_request_flag !== 1'b1 && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    flag_clear <= 1'b1;
    @(posedge pclk);
    flag_clear <= 1'b0;
  endtask

  task automatic ovf(input int ex);
    int n;
    wait_flag(n);
    wait_flag(n);
    chk("overflow period", 33'(ex), 33'(n + 1));
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(51));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pwr_mode = PWR_ACTIVE;
    wave_out_en = 1'b0;
    flag_clear = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_MODE, 33'h010);
    rd(ADDR_COUNT, 33'h000);
    rd(ADDR_OUT_SEL, 33'h0FE);
    rd(ADDR_CKSTOP, 33'h0FF);
    rd(20'h00010, 33'h100000000);
    $display("test reset done");
    wr(ADDR_MODE, 8'h0C);
    rd(ADDR_MODE, 33'h01C);
    rd(ADDR_COUNT, 33'h000);
    wr(ADDR_OUT_SEL, 8'($urandom()) & 8'hFE);
    rd(ADDR_OUT_SEL, 33'h0FE);
    $display("test registers done");
    wr(ADDR_CKSTOP, 8'hFE);
    rd(ADDR_CKSTOP, 33'h0FE);
    wr(ADDR_MODE, 8'h03);
    rd(ADDR_MODE, 33'h01B);
    repeat (400) @(posedge pclk);
    rd(ADDR_COUNT, 33'h000);
    wr(ADDR_COUNT, 8'hA5);
    rd(ADDR_COUNT, 33'h000);
    wr(ADDR_CKSTOP, 8'hFF);
    wr(ADDR_MODE, 8'h07);
    rd(ADDR_MODE, 33'h017);
    $display("test standby done");
    ovf(2048);
    wr(ADDR_MODE, 8'h06);
    ovf(8192);
    $display("test interval done");
    wave_out_en <= 1'b1;
    for (c = 0; c < 4; c++)
    begin
      wr(ADDR_MODE, {3'(c), 5'h0C});
      wave(32 >> c, 0);
    end
    pwr_mode <= PWR_WATCH;
    wave(0, 0);
    pwr_mode <= PWR_SLEEP;
    wave(4, 0);
    pwr_mode <= PWR_ACTIVE;
    wave_out_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("wave_out_oe", 33'h0, {32'h0, wave_out_oe});
    wave(0, 0);
    wave_out_en <= 1'b1;
    $display("test system output done");
    for (c = 4; c < 8; c++)
    begin
      wr(ADDR_MODE, {3'(c), 5'h0B});
      wave((3046 * (32 >> (c - 4))) / 100, 3);
    end
    pwr_mode <= PWR_SUBACTIVE;
    wave(122, 3);
    rd(ADDR_COUNT, 33'h000);
    wr(ADDR_OUT_SEL, 8'h01);
    rd(ADDR_OUT_SEL, 33'h0FF);
    pwr_mode <= PWR_WATCH;
    wave(30, 2);
    pwr_mode <= PWR_STANDBY;
    wave(30, 2);
    $display("test subclock output done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
